// ---- core/dac_board_regs.vh ----
// constants for the dac board select and update configuration logic
`ifndef DAC_BOARD_REGS_VH
`define DAC_BOARD_REGS_VH

// register byte offsets (ahb-lite, one aligned word each)
`define CTRL_OFF           8'h00
`define CHAN_BASE_OFF      8'h40
`define CHAN_LAST_OFF      8'h7C
`define CFG_OFF            8'h04
`define VME_ADDR_OFF       8'h08
`define VME_CYCLE_OFF      8'h0C
`define STATUS_OFF         8'h10
`define OUT_LO_OFF         8'h14
`define OUT_HI_OFF         8'h18

// control word fields
`define CTRL_ENABLE_BIT    15
`define CTRL_UPDATE_BIT    9
`define CTRL_CONNECTOR_BIT 8
`define CTRL_RESET         16'h0000

// short i/o address modifier codes
`define AM_SHORT_SUPER     6'h2D
`define AM_SHORT_USER      6'h29

// factory base address: low 16 bits of ff0060h; bits 4..0 are channel offset
`define BASE_FACTORY       16'h0060
`define SWITCH_MASK        16'hFFE0
`define CHAN_ADDR_LSB      1
`define CHAN_ADDR_MSB      4

// hclk at 125 mhz; channel word width
`define CHAN_WIDTH         12
`define NUM_CHANNELS       16
`define NUM_GROUPS         4
`define CFG_RESET          32'h0000_0060

`endif

// ---- core/dac_board_select.v ----
// bus select, privilege decode and update control of a 16-channel dac board
//
// Summary of operation
// - switch on needs zero, off needs one
// - select only when all assigned bits match
// - decode only in short i/o space
// - jumper absent supervisory, installed non-privileged
// - group without jumper updates on write
// - group with jumper holds until update
// - external trigger acts only when enabled
// - one isolation switch per channel
// - factory base address ff0060h
// - control bit 15 enables analog outputs
// - control update word converts the channels of groups with jumper installed
`timescale 1ns/1ps
`include "dac_board_regs.vh"
module dac_board_select #(
    parameter W = `CHAN_WIDTH
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire         hsel,
    input  wire [31:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire [31:0]  hwdata,
    input  wire         hready,
    output wire [31:0]  hrdata,
    output wire         hreadyout,
    output wire         hresp,
    input  wire [6:0]   low_address_select_switch,
    input  wire [8:0]   high_address_select_switch,
    input  wire         privilege_select_jumper,
    input  wire [3:0]   update_config_jumper_block,
    input  wire         ext_trigger_enable_jumper,
    input  wire         ext_trigger,
    output wire [15:0]  isolation_switch_closed,
    output wire         outputs_enabled,
    output wire [16*W-1:0] analog_output_connector
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: jumpers, switches and trigger are asynchronous
    // cleared at reset to the idle trigger level, so no false edge follows reset
    localparam PW = 7 + 9 + 1 + 4 + 1 + 1;
    wire [PW-1:0] pins_raw = {low_address_select_switch, high_address_select_switch,
                              privilege_select_jumper, update_config_jumper_block,
                              ext_trigger_enable_jumper, ext_trigger};
    reg  [PW-1:0] pins_meta_q;
    reg  [PW-1:0] pins_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_meta_q <= {PW{1'b0}};
            pins_q      <= {PW{1'b0}};
        end else begin
            pins_meta_q <= pins_raw;
            pins_q      <= pins_meta_q;
        end
    end
    wire [6:0] sw_low   = pins_q[PW-1 -: 7];
    wire [8:0] sw_high  = pins_q[PW-8 -: 9];
    wire       priv_jmp = pins_q[6];
    wire [3:0] grp_jmp  = pins_q[5:2];
    wire       trig_en  = pins_q[1];
    wire       trig_s   = pins_q[0];

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg  [15:0] ctrl_q;
    reg  [15:0] vme_addr_q;
    reg  [5:0]  vme_am_q;
    reg         vme_write_q;
    reg  [15:0] vme_data_q;
    reg         vme_strobe_q;
    reg         selected_q;
    reg         trig_prev_q;
    reg  [7:0]  miss_q;
    // miss_q wraps at 255: a debug count, not an error flag

    // ahb data phase state
    reg         dph_q;
    reg         dph_write_q;
    reg  [7:0]  dph_addr_q;
    reg  [31:0] rdata_q;

    wire take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // channel words from the four groups, flattened and indexed
    wire [16*W-1:0] applied_bus;
    wire [16*W-1:0] held_bus;
    wire [W-1:0]    applied [0:15];
    wire [W-1:0]    held    [0:15];

    ////////////////////////////////////////////////////////////////////////
    // backplane cycle decode, emulated as a register-driven cycle
    // switch on (=1 here) demands a zero on the address line
    wire [15:0] switch_expect = {~sw_high, ~sw_low[6:5], 5'b0_0000};
    wire        addr_match = ((vme_addr_q ^ switch_expect) & `SWITCH_MASK) == 16'h0000;
    wire [5:0]  am_wanted  = priv_jmp ? `AM_SHORT_USER : `AM_SHORT_SUPER;
    // only the short i/o code chosen by the jumper matches; any other modifier is ignored
    wire        am_match   = (vme_am_q == am_wanted);
    wire        board_sel  = addr_match && am_match;
    wire [3:0]  chan_idx   = vme_addr_q[`CHAN_ADDR_MSB:`CHAN_ADDR_LSB];
    // offset zero is shared: channel 0 on data writes after control unless control form
    wire        ctrl_form  = vme_data_q[`CTRL_ENABLE_BIT] && vme_data_q[14];
    wire        ctrl_wr    = vme_strobe_q && board_sel && vme_write_q && chan_idx == 4'h0
                             && ctrl_form;
    wire        chan_wr    = vme_strobe_q && board_sel && vme_write_q && !ctrl_wr;

    // decode runs a cycle after the data phase, from registered copies only
    wire        sw_update  = ctrl_wr && vme_data_q[`CTRL_UPDATE_BIT];
    wire        trig_rise  = trig_s && !trig_prev_q;
    wire        ext_update = trig_en && trig_rise;
    wire        update     = sw_update || ext_update;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q       <= `CTRL_RESET;
            vme_addr_q   <= `BASE_FACTORY;
            vme_am_q     <= `AM_SHORT_SUPER;
            vme_write_q  <= 1'b0;
            vme_data_q   <= 16'h0000;
            vme_strobe_q <= 1'b0;
            selected_q   <= 1'b0;
            trig_prev_q  <= 1'b0;
            miss_q       <= 8'h00;
            dph_q        <= 1'b0;
            dph_write_q  <= 1'b0;
            dph_addr_q   <= 8'h00;
            rdata_q      <= 32'h0000_0000;
        end else begin
            trig_prev_q  <= trig_s;
            vme_strobe_q <= 1'b0;
            if (vme_strobe_q) begin
                selected_q <= board_sel;
                if (!board_sel) begin
                    miss_q <= miss_q + 8'h01;
                end
            end
            if (ctrl_wr) begin
                ctrl_q <= vme_data_q;
            end
            dph_q       <= take;
            dph_write_q <= hwrite;
            dph_addr_q  <= haddr[7:0];
            if (dph_q && dph_write_q) begin
                case (dph_addr_q)
                    `VME_ADDR_OFF: begin
                        vme_addr_q <= hwdata[15:0];
                        vme_am_q   <= hwdata[21:16];
                    end
                    `VME_CYCLE_OFF: begin
                        vme_data_q   <= hwdata[15:0];
                        vme_write_q  <= hwdata[16];
                        vme_strobe_q <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
            if (take && !hwrite) begin
                case (haddr[7:0])
                    `CTRL_OFF:      rdata_q <= {16'h0000, ctrl_q};
                    `CFG_OFF:       rdata_q <= {5'h00, miss_q, trig_en, grp_jmp, priv_jmp,
                                                sw_high, sw_low[6:5],
                                                2'b00};
                    `VME_ADDR_OFF:  rdata_q <= {10'h000, vme_am_q, vme_addr_q};
                    `VME_CYCLE_OFF: rdata_q <= {15'h0000, vme_write_q, vme_data_q};
                    `STATUS_OFF:    rdata_q <= {28'h000_0000, selected_q, board_sel,
                                                am_match, addr_match};
                    default: begin
                        if (haddr[7:6] == 2'b01) begin
                            rdata_q <= {{(32-W){1'b0}}, applied[haddr[5:2]]};
                        end else if (haddr[7:6] == 2'b10) begin
                            // held words let software see a delayed load before the update
                            rdata_q <= {{(32-W){1'b0}}, held[haddr[5:2]]};
                        end else begin
                            rdata_q <= 32'h0000_0000;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // four channel groups; jumper installed selects delayed mode
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g = g + 1) begin : g_grp
            dac_channel_group #(.W(W)) u_grp (
                .hclk          (hclk),
                .hresetn       (hresetn),
                .delayed_mode  (grp_jmp[g]),
                .load_en       (chan_wr && chan_idx[3:2] == g),
                .load_idx      (chan_idx[1:0]),
                .load_data     (vme_data_q[W-1:0]),
                .update        (update),
                .held_words    (held_bus[g*4*W +: 4*W]),
                .applied_words (applied_bus[g*4*W +: 4*W])
            );
        end
        for (g = 0; g < 16; g = g + 1) begin : g_map
            assign applied[g] = applied_bus[g*W +: W];
            assign held[g]    = held_bus[g*W +: W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // switches close only when enabled and routed there; the connector always carries the applied words
    // control bits 15 and 8 drive all sixteen switches, so they always move together
    assign outputs_enabled = ctrl_q[`CTRL_ENABLE_BIT];
    wire   route_conn      = outputs_enabled && ctrl_q[`CTRL_CONNECTOR_BIT];
    assign isolation_switch_closed = {16{route_conn}};
    assign analog_output_connector = applied_bus;
endmodule // dac_board_select

// ---- core/dac_channel_group.v ----
// one bank of four dac channels with immediate or delayed update
`timescale 1ns/1ps
module dac_channel_group #(
    parameter W = 12
) (
    input  wire           hclk,
    input  wire           hresetn,
    input  wire           delayed_mode,
    input  wire           load_en,
    input  wire [1:0]     load_idx,
    input  wire [W-1:0]   load_data,
    input  wire           update,
    output wire [4*W-1:0] held_words,
    output wire [4*W-1:0] applied_words
);
    reg [W-1:0] hold_q [0:3];
    reg [W-1:0] out_q  [0:3];
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ch
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hold_q[i] <= {W{1'b0}};
                    out_q[i]  <= {W{1'b0}};
                end else begin
                    if (load_en && load_idx == i) begin
                        hold_q[i] <= load_data;
                    end
                    if (!delayed_mode && load_en && load_idx == i) begin
                        out_q[i] <= load_data;
                    end else if (delayed_mode && update) begin
                        // a write in the update cycle is held, the old held word applies
                        out_q[i] <= hold_q[i];
                    end
                end
            end
            assign held_words[i*W +: W]    = hold_q[i];
            assign applied_words[i*W +: W] = out_q[i];
        end
    endgenerate
endmodule // dac_channel_group

// ---- verification/ahb_cpu_master.sv ----
// ahb-lite single-word master standing in for the backplane cpu
`timescale 1ns/1ps
module ahb_cpu_master (
    input  wire         hclk,
    input  wire         hready,
    input  wire [31:0]  hrdata,
    output logic        hsel,
    output logic [31:0] haddr,
    output logic [1:0]  htrans,
    output logic        hwrite,
    output logic [2:0]  hsize,
    output logic [31:0] hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'b010;
    end
    // address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'b10, w};
        do @(posedge hclk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule // ahb_cpu_master

// ---- verification/dac_board_select_chk.sv ----
// assertions on the ports of the dac board select logic
`timescale 1ns/1ps
module dac_board_select_chk #(parameter W = 12) (
    input wire            hclk,
    input wire            hresetn,
    input wire            hsel,
    input wire [1:0]      htrans,
    input wire            hwrite,
    input wire            hready,
    input wire [31:0]     hrdata,
    input wire            hreadyout,
    input wire            hresp,
    input wire            ext_trigger,
    input wire [15:0]     isolation_switch_closed,
    input wire            outputs_enabled,
    input wire [16*W-1:0] analog_output_connector
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [3:0] quiet_q;
    sequence req_taken;
        hsel && hready && htrans[1];
    endsequence
    // cycles since the last write or trigger; saturates so it never wraps
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            quiet_q <= 4'hF;
        else if ((hsel && hready && htrans[1] && hwrite) || ext_trigger)
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hF)
            quiet_q <= quiet_q + 4'h1;
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_ready_after: assert property (req_taken |=> hreadyout [*2]) else $error("wait inserted");
    a_ready_idle: assert property (!hsel |-> hreadyout) else $error("hreadyout low when idle");
    a_rdata_hold: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("hrdata moved without a read");
    a_iso_all: assert property (isolation_switch_closed inside {16'h0000, 16'hFFFF})
        else $error("isolation switches split");
    a_iso_enable: assert property (|isolation_switch_closed |-> outputs_enabled)
        else $error("switch closed while disabled");
    a_out_cause: assert property ($changed(analog_output_connector) |-> quiet_q <= 4'hA)
        else $error("output moved without cause");
    a_en_cause: assert property ($changed(outputs_enabled) |-> quiet_q <= 4'h8)
        else $error("enable moved without a write");
endmodule // dac_board_select_chk
bind dac_board_select dac_board_select_chk #(.W(W)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_trigger(ext_trigger), .isolation_switch_closed(isolation_switch_closed),
    .outputs_enabled(outputs_enabled), .analog_output_connector(analog_output_connector));

// ---- verification/testbench.sv ----
// self-checking bench for the dac board select logic
`timescale 1ns/1ps
module testbench;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [8:0]  sw_hi = 9'h1FF;
    logic [6:0]  sw_lo = 7'h00;
    logic        priv = 1'b0;
    logic [3:0]  grp = 4'h0;
    logic        trig_en = 1'b0;
    logic        trig = 1'b0;
    logic [5:0]  am = 6'h2D;
    logic [31:0] q;
    int          err_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    wire         hsel, hwrite, hreadyout, hresp, en;
    wire [1:0]   htrans;
    wire [2:0]   hsize;
    wire [31:0]  haddr, hwdata, hrdata;
    wire [15:0]  iso;
    wire [191:0] aout;
    always #4 hclk = ~hclk;
    ahb_cpu_master i_master (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    dac_board_select i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .low_address_select_switch(sw_lo), .high_address_select_switch(sw_hi),
        .privilege_select_jumper(priv), .update_config_jumper_block(grp),
        .ext_trigger_enable_jumper(trig_en), .ext_trigger(trig),
        .isolation_switch_closed(iso), .outputs_enabled(en), .analog_output_connector(aout));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] ch(input int n);
        return aout[n*12 +: 12];
    endfunction
    // one emulated short i/o write: address and modifier, then the data cycle
    task automatic vme(input logic [15:0] a, input logic [5:0] m, input logic [15:0] d);
        i_master.xfer(1'b1, 32'h0000_0008, {10'h000, m, a}, q);
        i_master.xfer(1'b1, 32'h0000_000C, {15'h0000, 1'b1, d}, q);
        repeat (4) @(posedge hclk);
    endtask
    task automatic pulse();
        trig <= 1'b1;
        repeat (2) @(posedge hclk);
        trig <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_factory();
        vme(16'h0060, am, 16'hC100);
        check(en, 1'b1);
        check(iso, 16'hFFFF);
        vme(16'h0066, am, 16'h0ABC);
        check(ch(3), 32'h0000_0ABC);
        i_master.xfer(1'b0, 32'h0000_0020, 32'h0000_0000, q);
        check(q, 32'h0000_0000);
        i_master.xfer(1'b0, 32'h0000_004C, 32'h0000_0000, q);
        check(q, 32'h0000_0ABC);
    endtask
    task automatic t_decode();
        vme(16'h0066, 6'h29, 16'h0123);
        vme(16'h0066, 6'h3D, 16'h0123);
        check(ch(3), 32'h0000_0ABC);
        vme(16'h0160, am, 16'h0321);
        check(ch(0), 32'h0000_0000);
        sw_hi <= 9'h1FD;
        vme(16'h0160, am, 16'h0321);
        check(ch(0), 32'h0000_0321);
        sw_hi <= 9'h1FF;
        vme(16'h0004, am, 16'h0456);
        check(ch(2), 32'h0000_0000);
        sw_lo <= 7'h60;
        vme(16'h0004, am, 16'h0456);
        check(ch(2), 32'h0000_0456);
        sw_lo <= 7'h00;
    endtask
    task automatic t_priv();
        priv <= 1'b1;
        vme(16'h0066, 6'h2D, 16'h0123);
        check(ch(3), 32'h0000_0ABC);
        am = 6'h29;
        vme(16'h0066, am, 16'h0123);
        check(ch(3), 32'h0000_0123);
    endtask
    task automatic t_delay();
        grp <= 4'h2;
        vme(16'h006A, am, 16'h0555);
        check(ch(5), 32'h0000_0000);
        i_master.xfer(1'b0, 32'h0000_0094, 32'h0000_0000, q);
        check(q, 32'h0000_0555);
        vme(16'h0060, am, 16'hC300);
        check(ch(5), 32'h0000_0555);
    endtask
    task automatic t_trigger();
        vme(16'h006A, am, 16'h0777);
        pulse();
        check(ch(5), 32'h0000_0555);
        trig_en <= 1'b1;
        pulse();
        check(ch(5), 32'h0000_0777);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_factory();
        t_decode();
        t_priv();
        t_delay();
        t_trigger();
        end_sim();
    end
endmodule // testbench
